// ---- rtl/iex_pkg.sv ----
// constants and types shared by the instruction exception unit
package iex_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // opcode field positions
  localparam int unsigned GRP_HI  = 15;
  localparam int unsigned GRP_LO  = 12;
  localparam int unsigned SUB_HI  = 11;
  localparam int unsigned SUB_LO  = 8;
  localparam int unsigned TVEC_HI = 7;
  localparam int unsigned TVEC_LO = 0;

  // group codes in opcode[15:12]
  localparam logic [3:0] GRP_PLAIN      = 4'h0;
  localparam logic [3:0] GRP_JUMP       = 4'h1;
  localparam logic [3:0] GRP_JUMP_SUB   = 4'h2;
  localparam logic [3:0] GRP_BRA_ALWAYS = 4'h3;
  localparam logic [3:0] GRP_BRA_SUB    = 4'h4;
  localparam logic [3:0] GRP_RET_SUB    = 4'h5;
  localparam logic [3:0] GRP_RET_EXC    = 4'h6;
  localparam logic [3:0] GRP_BRA_TRUE   = 4'h7;
  localparam logic [3:0] GRP_BRA_FALSE  = 4'h8;
  localparam logic [3:0] GRP_TRAP       = 4'h9;
  localparam logic [3:0] GRP_XFER       = 4'ha;
  localparam logic [3:0] GRP_MEMOP      = 4'hb;

  // sub codes of the control/system transfer group, opcode[11:8]
  localparam logic [3:0] SUB_LDC_REG = 4'h0;
  localparam logic [3:0] SUB_LDC_MEM = 4'h1;
  localparam logic [3:0] SUB_STC_REG = 4'h2;
  localparam logic [3:0] SUB_STC_MEM = 4'h3;
  localparam logic [3:0] SUB_LDS_REG = 4'h4;
  localparam logic [3:0] SUB_LDS_MEM = 4'h5;
  localparam logic [3:0] SUB_STS_REG = 4'h6;
  localparam logic [3:0] SUB_STS_MEM = 4'h7;

  // stack and vector arithmetic
  localparam logic [31:0] STACK_STEP = 32'h0000_0004;
  localparam logic [1:0]  ALIGN_OK   = 2'h0;
  localparam logic [1:0]  VEC_PAD    = 2'h0;

  // default vector numbers (plain defaults)
  localparam logic [7:0] VEC_SLOT_DEF = 8'h06;
  localparam logic [7:0] VEC_GEN_DEF  = 8'h04;
  localparam logic [7:0] VEC_AERR_DEF = 8'h09;

  typedef enum logic [2:0] {KIND_NONE, KIND_TRAP, KIND_SLOT, KIND_GEN, KIND_IRQ,
                            KIND_AERR} iex_kind_t;

  typedef enum logic [2:0] {ST_IDLE, ST_PUSH_SR, ST_PUSH_PC, ST_FETCH,
                            ST_BRANCH} iex_state_t;

endpackage

// ---- rtl/iex_decode.sv ----
// opcode classifier for branch, slot, trap and undefined codes
`timescale 1ns/1ps
module iex_decode
  import iex_pkg::*;
(
  input  wire logic [15:0] opcode,
  output logic             is_delayed,
  output logic             is_pc_rewrite,
  output logic             is_irq_block,
  output logic             is_undef,
  output logic             is_trap,
  output logic [7:0]       trap_vec
);

  logic [3:0] grp;
  logic [3:0] sub;

  assign grp      = opcode[GRP_HI:GRP_LO];
  assign sub      = opcode[SUB_HI:SUB_LO];
  assign trap_vec = opcode[TVEC_HI:TVEC_LO];

  always_comb
  begin
    is_delayed    = 1'b0;
    is_pc_rewrite = 1'b0;
    is_irq_block  = 1'b0;
    is_undef      = 1'b0;
    is_trap       = 1'b0;
    case (grp)
      GRP_JUMP, GRP_JUMP_SUB, GRP_BRA_ALWAYS, GRP_BRA_SUB, GRP_RET_SUB, GRP_RET_EXC:
      begin
        is_delayed    = 1'b1; // [RULE3]
        is_pc_rewrite = 1'b1; // [RULE4]
      end
      GRP_BRA_TRUE, GRP_BRA_FALSE:
        is_pc_rewrite = 1'b1; // [RULE4]
      GRP_TRAP:
      begin
        is_pc_rewrite = 1'b1; // [RULE4]
        is_trap       = 1'b1;
      end
      GRP_XFER:
        case (sub)
          SUB_LDC_REG, SUB_LDC_MEM, SUB_STC_REG, SUB_STC_MEM,
          SUB_LDS_REG, SUB_LDS_MEM, SUB_STS_REG, SUB_STS_MEM:
            is_irq_block = 1'b1; // [RULE10]
          default:
            is_undef = 1'b1;
        endcase
      GRP_PLAIN, GRP_MEMOP:
        is_undef = 1'b0;
      default:
        is_undef = 1'b1;
    endcase
  end

endmodule

// ---- rtl/iex_accept.sv ----
// acceptance gating and pending address error hold
`timescale 1ns/1ps
module iex_accept
  import iex_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        dec_take,
  input  wire logic        in_slot,
  input  wire logic        irq_blocked,
  input  wire logic        aerr_req,
  input  wire logic [31:0] aerr_next_pc,
  input  wire logic        irq_req,
  input  wire logic        is_undef,
  input  wire logic        is_pc_rewrite,
  input  wire logic        is_trap,
  output logic             take_aerr,
  output logic             take_irq,
  output logic             take_slot,
  output logic             take_gen,
  output logic             take_trap,
  output logic [31:0]      aerr_pc
);

  logic        aerr_pend_r;
  logic        aerr_pend_nxt;
  logic [31:0] aerr_pc_r;
  logic [31:0] aerr_pc_nxt;

  always_comb
  begin
    take_aerr = dec_take && aerr_pend_r && !in_slot;                 // [RULE8] [RULE17]
    take_irq  = dec_take && irq_req && !in_slot && !irq_blocked &&
                !take_aerr;                                          // [RULE8] [RULE9]
    take_slot = dec_take && in_slot && (is_undef || is_pc_rewrite);  // [RULE2] [RULE4]
    take_gen  = dec_take && !in_slot && is_undef && !take_aerr && !take_irq; // [RULE7]
    take_trap = dec_take && !in_slot && is_trap && !take_aerr && !take_irq;  // [RULE1]
    // a new request wins over the clear of the one being taken
    aerr_pend_nxt = (aerr_pend_r && !take_aerr) || aerr_req;         // [RULE11]
    aerr_pc_nxt   = aerr_req ? aerr_next_pc : aerr_pc_r;
    aerr_pc       = aerr_pc_r;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aerr_pend_r <= 1'b0;
      aerr_pc_r   <= 32'h0000_0000;
    end
    else
    begin
      aerr_pend_r <= aerr_pend_nxt;
      aerr_pc_r   <= aerr_pc_nxt;
    end
  end

endmodule

// ---- rtl/iex_top.sv ----
// instruction exception unit: detection, acceptance and exception sequence
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (RULE1) trap: push status, next pc, vector
// (RULE2) bad or pc-writing slot op raises slot
// (RULE3) six delayed branches open a delay slot
// (RULE4) nine pc-writing ops flagged inside slot
// (RULE5) slot exception stacks status then branch target
// (RULE6) slot exception fetches vector, branches non-delayed
// (RULE7) undefined outside slot stacks own address
// (RULE8) no address error or interrupt in slot
// (RULE9) after transfer op block interrupts only
// (RULE10) control/system load/store ops block interrupts
// (RULE11) held-off exception waits for allowed decode
// (RULE12) misaligned stack pointer on push errors
// (RULE13) misaligned vector base on fetch errors
// (RULE14) stacking error: finish, then address error
// (RULE15) errors while stacking address error ignored
// (RULE16) faulty push still writes, sp minus four
// (RULE17) address error after bus, instructions done
// (RULE18) address error stacks status, next pc
// (RULE19) entry is base plus four times vector
module iex_top
  import iex_pkg::*;
#(
  parameter logic [7:0] VEC_SLOT = VEC_SLOT_DEF,
  parameter logic [7:0] VEC_GEN  = VEC_GEN_DEF,
  parameter logic [7:0] VEC_AERR = VEC_AERR_DEF
)
(
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        DEC_VALID,
  input  wire logic [15:0] DEC_OPCODE,
  input  wire logic [31:0] DEC_PC,
  input  wire logic [31:0] DEC_NEXT_PC,
  input  wire logic [31:0] BR_TARGET,
  input  wire logic [31:0] SR_IN,
  input  wire logic [31:0] SP_IN,
  input  wire logic [31:0] VBR_IN,
  input  wire logic        IRQ_REQ,
  input  wire logic [7:0]  IRQ_VEC,
  input  wire logic        AERR_REQ,
  input  wire logic [31:0] AERR_NEXT_PC,
  input  wire logic [31:0] BUS_RDATA,
  input  wire logic        BUS_ACK,
  output logic             BUS_REQ,
  output logic             BUS_WR,
  output logic [31:0]      BUS_ADDR,
  output logic [31:0]      BUS_WDATA,
  output logic             EXC_BUSY,
  output logic             BRANCH_VALID,
  output logic [31:0]      BRANCH_ADDR,
  output logic             SP_WR,
  output logic [31:0]      SP_OUT,
  output logic             IRQ_ACK,
  output logic             AERR_SIG,
  output logic [2:0]       EXC_KIND
);

  if (VEC_SLOT == VEC_AERR || VEC_GEN == VEC_AERR)
    $error("iex_top: address error vector must differ from illegal vectors");

  ////////////////////////////////////////////////////////////////////////////
  // decode and acceptance
  logic       is_delayed;
  logic       is_pc_rewrite;
  logic       is_irq_block;
  logic       is_undef;
  logic       is_trap;
  logic [7:0] trap_vec;
  logic       dec_take;
  logic       take_aerr;
  logic       take_irq;
  logic       take_slot;
  logic       take_gen;
  logic       take_trap;
  logic       take_any;
  logic [31:0] aerr_pc;

  iex_decode u_decode (
    .opcode        (DEC_OPCODE),
    .is_delayed    (is_delayed),
    .is_pc_rewrite (is_pc_rewrite),
    .is_irq_block  (is_irq_block),
    .is_undef      (is_undef),
    .is_trap       (is_trap),
    .trap_vec      (trap_vec)
  );

  iex_state_t  state_r;
  iex_state_t  state_nxt;
  logic        in_slot_r;
  logic        in_slot_nxt;
  logic        blk_r;
  logic        blk_nxt;

  assign dec_take = DEC_VALID && (state_r == ST_IDLE);

  iex_accept u_accept (
    .clk           (CLK),
    .rst_b         (RST_B),
    .dec_take      (dec_take),
    .in_slot       (in_slot_r),
    .irq_blocked   (blk_r),
    .aerr_req      (AERR_REQ),
    .aerr_next_pc  (AERR_NEXT_PC),
    .irq_req       (IRQ_REQ),
    .is_undef      (is_undef),
    .is_pc_rewrite (is_pc_rewrite),
    .is_trap       (is_trap),
    .take_aerr     (take_aerr),
    .take_irq      (take_irq),
    .take_slot     (take_slot),
    .take_gen      (take_gen),
    .take_trap     (take_trap),
    .aerr_pc       (aerr_pc)
  );

  assign take_any = take_aerr || take_irq || take_slot || take_gen || take_trap;

  ////////////////////////////////////////////////////////////////////////////
  // exception sequence state
  iex_kind_t   kind_r;
  iex_kind_t   kind_nxt;
  logic [7:0]  vec_r;
  logic [7:0]  vec_nxt;
  logic [31:0] sp_r;
  logic [31:0] sp_nxt;
  logic [31:0] sr_r;
  logic [31:0] sr_nxt;
  logic [31:0] pc_r;
  logic [31:0] pc_nxt;
  logic [31:0] vbr_r;
  logic [31:0] vbr_nxt;
  logic [31:0] hnd_r;
  logic [31:0] hnd_nxt;
  logic        stk_err_r;
  logic        stk_err_nxt;
  logic        ack;
  logic        may_err;

  // bus and pipeline outputs
  logic        bus_req_r;
  logic        bus_req_nxt;
  logic        bus_wr_r;
  logic        bus_wr_nxt;
  logic [31:0] bus_addr_r;
  logic [31:0] bus_addr_nxt;
  logic [31:0] bus_wdata_r;
  logic [31:0] bus_wdata_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        br_valid_r;
  logic        br_valid_nxt;
  logic [31:0] br_addr_r;
  logic [31:0] br_addr_nxt;
  logic        sp_wr_r;
  logic        sp_wr_nxt;
  logic [31:0] sp_out_r;
  logic [31:0] sp_out_nxt;
  logic        irq_ack_r;
  logic        irq_ack_nxt;
  logic        aerr_sig_r;
  logic        aerr_sig_nxt;

  assign ack     = bus_req_r && BUS_ACK;
  assign may_err = (kind_r != KIND_AERR); // [RULE15]

  always_comb
  begin
    state_nxt    = state_r;
    kind_nxt     = kind_r;
    vec_nxt      = vec_r;
    sp_nxt       = sp_r;
    sr_nxt       = sr_r;
    pc_nxt       = pc_r;
    vbr_nxt      = vbr_r;
    hnd_nxt      = hnd_r;
    stk_err_nxt  = stk_err_r;
    in_slot_nxt  = in_slot_r;
    blk_nxt      = blk_r;
    br_valid_nxt = 1'b0;
    br_addr_nxt  = br_addr_r;
    sp_wr_nxt    = 1'b0;
    sp_out_nxt   = sp_out_r;
    irq_ack_nxt  = 1'b0;
    aerr_sig_nxt = 1'b0;
    case (state_r)
      ST_IDLE:
        if (take_any)
        begin
          state_nxt   = ST_PUSH_SR;
          sp_nxt      = SP_IN;
          sr_nxt      = SR_IN;
          vbr_nxt     = VBR_IN;
          stk_err_nxt = 1'b0;
          in_slot_nxt = 1'b0;
          blk_nxt     = 1'b0;
          if (take_aerr)
          begin
            kind_nxt = KIND_AERR;
            vec_nxt  = VEC_AERR;
            pc_nxt   = aerr_pc;          // [RULE18]
          end
          else if (take_irq)
          begin
            kind_nxt    = KIND_IRQ;
            vec_nxt     = IRQ_VEC;
            pc_nxt      = DEC_PC;
            irq_ack_nxt = 1'b1;
          end
          else if (take_slot)
          begin
            kind_nxt = KIND_SLOT;
            vec_nxt  = VEC_SLOT;         // [RULE6]
            pc_nxt   = BR_TARGET;        // [RULE5]
          end
          else if (take_gen)
          begin
            kind_nxt = KIND_GEN;
            vec_nxt  = VEC_GEN;
            pc_nxt   = DEC_PC;           // [RULE7]
          end
          else
          begin
            kind_nxt = KIND_TRAP;
            vec_nxt  = trap_vec;         // [RULE1]
            pc_nxt   = DEC_NEXT_PC;      // [RULE1]
          end
        end
        else if (DEC_VALID)
        begin
          in_slot_nxt = is_delayed;      // [RULE3] [RULE8]
          blk_nxt     = is_irq_block;    // [RULE9] [RULE11]
        end
      ST_PUSH_SR:
        if (ack)
        begin
          sp_nxt    = sp_r - STACK_STEP; // [RULE16]
          state_nxt = ST_PUSH_PC;
          if (sp_r[1:0] != ALIGN_OK && may_err)
          begin
            stk_err_nxt  = 1'b1;         // [RULE12]
            aerr_sig_nxt = 1'b1;
          end
        end
      ST_PUSH_PC:
        if (ack)
        begin
          sp_nxt    = sp_r - STACK_STEP; // [RULE16]
          state_nxt = ST_FETCH;
          if (sp_r[1:0] != ALIGN_OK && may_err)
          begin
            stk_err_nxt  = 1'b1;         // [RULE12]
            aerr_sig_nxt = 1'b1;
          end
        end
      ST_FETCH:
        if (ack)
        begin
          hnd_nxt   = BUS_RDATA;         // [RULE19]
          state_nxt = ST_BRANCH;
          if (vbr_r[1:0] != ALIGN_OK && may_err)
          begin
            stk_err_nxt  = 1'b1;         // [RULE13]
            aerr_sig_nxt = 1'b1;
          end
        end
      ST_BRANCH:
        if (stk_err_r)
        begin
          // finished the sequence; chain straight into address error handling
          kind_nxt    = KIND_AERR;       // [RULE14]
          vec_nxt     = VEC_AERR;
          pc_nxt      = hnd_r;           // [RULE18]
          sr_nxt      = SR_IN;
          stk_err_nxt = 1'b0;
          state_nxt   = ST_PUSH_SR;
        end
        else
        begin
          br_valid_nxt = 1'b1;           // [RULE6]
          br_addr_nxt  = hnd_r;
          sp_wr_nxt    = 1'b1;
          sp_out_nxt   = sp_r;
          state_nxt    = ST_IDLE;
        end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus request built from the coming state
  always_comb
  begin
    bus_req_nxt   = 1'b0;
    bus_wr_nxt    = 1'b0;
    bus_addr_nxt  = bus_addr_r;
    bus_wdata_nxt = bus_wdata_r;
    busy_nxt      = (state_nxt != ST_IDLE);
    case (state_nxt)
      ST_PUSH_SR:
      begin
        bus_req_nxt   = 1'b1;
        bus_wr_nxt    = 1'b1;
        bus_addr_nxt  = sp_nxt - STACK_STEP; // [RULE16]
        bus_wdata_nxt = sr_nxt;              // [RULE1] [RULE5] [RULE18]
      end
      ST_PUSH_PC:
      begin
        bus_req_nxt   = 1'b1;
        bus_wr_nxt    = 1'b1;
        bus_addr_nxt  = sp_nxt - STACK_STEP; // [RULE16]
        bus_wdata_nxt = pc_nxt;              // [RULE1] [RULE5] [RULE7]
      end
      ST_FETCH:
      begin
        bus_req_nxt   = 1'b1;
        bus_wr_nxt    = 1'b0;
        bus_addr_nxt  = vbr_nxt + {22'h0, vec_nxt, VEC_PAD}; // [RULE19]
      end
      ST_IDLE, ST_BRANCH:
        bus_req_nxt = 1'b0;
      default:
        bus_req_nxt = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_r     <= ST_IDLE;
      kind_r      <= KIND_NONE;
      vec_r       <= 8'h00;
      sp_r        <= 32'h0000_0000;
      sr_r        <= 32'h0000_0000;
      pc_r        <= 32'h0000_0000;
      vbr_r       <= 32'h0000_0000;
      hnd_r       <= 32'h0000_0000;
      stk_err_r   <= 1'b0;
      in_slot_r   <= 1'b0;
      blk_r       <= 1'b0;
      bus_req_r   <= 1'b0;
      bus_wr_r    <= 1'b0;
      bus_addr_r  <= 32'h0000_0000;
      bus_wdata_r <= 32'h0000_0000;
      busy_r      <= 1'b0;
      br_valid_r  <= 1'b0;
      br_addr_r   <= 32'h0000_0000;
      sp_wr_r     <= 1'b0;
      sp_out_r    <= 32'h0000_0000;
      irq_ack_r   <= 1'b0;
      aerr_sig_r  <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      kind_r      <= kind_nxt;
      vec_r       <= vec_nxt;
      sp_r        <= sp_nxt;
      sr_r        <= sr_nxt;
      pc_r        <= pc_nxt;
      vbr_r       <= vbr_nxt;
      hnd_r       <= hnd_nxt;
      stk_err_r   <= stk_err_nxt;
      in_slot_r   <= in_slot_nxt;
      blk_r       <= blk_nxt;
      bus_req_r   <= bus_req_nxt;
      bus_wr_r    <= bus_wr_nxt;
      bus_addr_r  <= bus_addr_nxt;
      bus_wdata_r <= bus_wdata_nxt;
      busy_r      <= busy_nxt;
      br_valid_r  <= br_valid_nxt;
      br_addr_r   <= br_addr_nxt;
      sp_wr_r     <= sp_wr_nxt;
      sp_out_r    <= sp_out_nxt;
      irq_ack_r   <= irq_ack_nxt;
      aerr_sig_r  <= aerr_sig_nxt;
    end
  end

  assign BUS_REQ      = bus_req_r;
  assign BUS_WR       = bus_wr_r;
  assign BUS_ADDR     = bus_addr_r;
  assign BUS_WDATA    = bus_wdata_r;
  assign EXC_BUSY     = busy_r;
  assign BRANCH_VALID = br_valid_r;
  assign BRANCH_ADDR  = br_addr_r;
  assign SP_WR        = sp_wr_r;
  assign SP_OUT       = sp_out_r;
  assign IRQ_ACK      = irq_ack_r;
  assign AERR_SIG     = aerr_sig_r;
  assign EXC_KIND     = kind_r;

endmodule

// ---- bench/iex_checker.sv ----
// port assertions for the instruction exception unit
`timescale 1ns/1ps
module iex_checker
  import iex_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        DEC_VALID,
  input wire logic [15:0] DEC_OPCODE,
  input wire logic [31:0] SR_IN,
  input wire logic [31:0] SP_IN,
  input wire logic        BUS_ACK,
  input wire logic        BUS_REQ,
  input wire logic        BUS_WR,
  input wire logic [31:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  input wire logic        EXC_BUSY,
  input wire logic        BRANCH_VALID,
  input wire logic        SP_WR,
  input wire logic [31:0] SP_OUT,
  input wire logic        IRQ_ACK,
  input wire logic        AERR_SIG,
  input wire logic [2:0]  EXC_KIND
);
  logic [31:0] last_wa_r;
  logic [31:0] last_wa_nxt;
  logic [3:0]  grp;

  assign grp = DEC_OPCODE[GRP_HI:GRP_LO];

  // address of the most recent acknowledged push
  always_comb
  begin
    last_wa_nxt = last_wa_r;
    if (BUS_REQ && BUS_WR && BUS_ACK)
      last_wa_nxt = BUS_ADDR;
  end

  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      last_wa_r <= 32'h0;
    else
      last_wa_r <= last_wa_nxt;

  ////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_wr_ack;
    BUS_REQ && BUS_WR && BUS_ACK;
  endsequence
  sequence s_delayed;
    DEC_VALID && !EXC_BUSY && grp >= GRP_JUMP && grp <= GRP_RET_EXC;
  endsequence
  sequence s_xfer;
    DEC_VALID && !EXC_BUSY && grp == GRP_XFER && !DEC_OPCODE[11];
  endsequence
  sequence s_plain;
    DEC_VALID && !EXC_BUSY && grp == GRP_PLAIN;
  endsequence

  property p_exc_start;
    DEC_VALID && !EXC_BUSY && (grp == GRP_TRAP || grp >= 4'hc) |=> EXC_BUSY && BUS_REQ
      && BUS_WR && BUS_ADDR == $past(SP_IN) - STACK_STEP && BUS_WDATA == $past(SR_IN);
  endproperty
  a_exc_start: assert property (p_exc_start) else $error("first push wrong");

  property p_push_step;
    s_wr_ack ##1 (BUS_REQ && BUS_WR) |-> BUS_ADDR == $past(BUS_ADDR) - STACK_STEP;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push step wrong");

  property p_branch_end;
    BRANCH_VALID |-> SP_WR && !EXC_BUSY && !BUS_REQ && $past(EXC_BUSY && !BUS_REQ);
  endproperty
  a_branch_end: assert property (p_branch_end) else $error("branch timing wrong");

  property p_sp_final;
    SP_WR |-> SP_OUT == last_wa_r;
  endproperty
  a_sp_final: assert property (p_sp_final) else $error("final sp wrong");

  property p_misalign;
    $rose(EXC_BUSY) && BUS_ADDR[1:0] != ALIGN_OK && EXC_KIND != KIND_AERR
      |-> ##[0:40] AERR_SIG;
  endproperty
  a_misalign: assert property (p_misalign) else $error("no error on bad sp");

  property p_aerr_quiet;
    EXC_BUSY && EXC_KIND == KIND_AERR |-> !AERR_SIG;
  endproperty
  a_aerr_quiet: assert property (p_aerr_quiet) else $error("nested error");

  property p_irq_ack;
    IRQ_ACK |-> EXC_BUSY && BUS_REQ && BUS_WR && EXC_KIND == KIND_IRQ
      && $past(DEC_VALID && !EXC_BUSY);
  endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("irq ack wrong");

  property p_slot_block;
    s_delayed ##1 s_plain |=> !EXC_BUSY && !IRQ_ACK;
  endproperty
  a_slot_block: assert property (p_slot_block) else $error("slot not shielded");

  property p_xfer_block;
    s_xfer ##1 s_plain |=> !IRQ_ACK;
  endproperty
  a_xfer_block: assert property (p_xfer_block) else $error("irq after xfer");
endmodule

bind iex_top iex_checker u_chk (.*);

// ---- bench/tb_instruction_exception_unit.sv ----
// self-checking bench for the instruction exception unit
`timescale 1ns/1ps
module tb_instruction_exception_unit
  import iex_pkg::*;
;
  logic        CLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        DEC_VALID = 1'b0;
  logic [15:0] DEC_OPCODE = 16'h0;
  logic [31:0] DEC_PC = 32'h0;
  logic [31:0] DEC_NEXT_PC = 32'h0;
  logic [31:0] BR_TARGET = 32'h0;
  logic [31:0] SR_IN = 32'h0;
  logic [31:0] SP_IN = 32'h0;
  logic [31:0] VBR_IN = 32'h0;
  logic        IRQ_REQ = 1'b0;
  logic [7:0]  IRQ_VEC = 8'h0;
  logic        AERR_REQ = 1'b0;
  logic [31:0] AERR_NEXT_PC = 32'h0;
  logic [31:0] BUS_RDATA = 32'h0;
  logic        BUS_ACK = 1'b0;
  logic        BUS_REQ, BUS_WR, EXC_BUSY, BRANCH_VALID, SP_WR, IRQ_ACK, AERR_SIG;
  logic [31:0] BUS_ADDR, BUS_WDATA, BRANCH_ADDR, SP_OUT;
  logic [2:0]  EXC_KIND;
  logic [31:0] sr_v, sp_v, vbr_v, pc_v, brt_v, anpc_v;
  logic [7:0]  ivec_v;
  logic [65:0] exp_q[$];
  int          fails = 0;
  int          n_compared = 0;

  iex_top u_dut (.*);

  always #2 CLK = ~CLK;

  ////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // entry: kind (0 read, 1 write, 2 branch, 3 write with undefined data), addr, data
  task automatic check(input logic [65:0] got);
    logic [65:0] e;
    n_compared++;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
    if (e[65:64] === 2'h3 ? got[65:32] !== {2'h1, e[63:32]} : got !== e)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  always @(posedge CLK)
    if (RST_B)
    begin
      if (BUS_REQ && BUS_ACK)
        check({1'b0, BUS_WR, BUS_ADDR, BUS_WR ? BUS_WDATA : 32'h0});
      if (BRANCH_VALID)
        check({2'h2, BRANCH_ADDR, SP_OUT});
    end

  // memory side: random ack delay, handler = inverted entry address
  always @(posedge CLK)
  begin
    BUS_ACK <= BUS_REQ && !BUS_ACK && ($urandom % 3 != 0);
    BUS_RDATA <= ~BUS_ADDR;
  end

  ////////////////////////////////////////
  task automatic exp_seq(input logic [31:0] sp, input logic [31:0] pc, input logic [7:0] vec,
                         input bit aerr);
    logic [31:0] va;
    logic [1:0]  wk;
    va = vbr_v + {22'h0, vec, 2'h0};
    wk = (sp[1:0] != 2'h0) ? 2'h3 : 2'h1;
    exp_q.push_back({wk, sp - 32'h4, sr_v});
    exp_q.push_back({wk, sp - 32'h8, pc});
    exp_q.push_back({2'h0, va, 32'h0});
    if (!aerr && (sp[1:0] != 2'h0 || vbr_v[1:0] != 2'h0))
      exp_seq(sp - 32'h8, ~va, VEC_AERR_DEF, 1'b1);
    else
      exp_q.push_back({2'h2, ~va, sp - 32'h8});
  endtask

  task automatic setup(input logic [1:0] sp_off, input logic [1:0] vb_off);
    sr_v = $urandom;
    sp_v = ($urandom & 32'hffff_fff0) | 32'h100 | sp_off;
    vbr_v = ($urandom & 32'hffff_0000) | vb_off;
    pc_v = $urandom & 32'hffff_fff0;
    brt_v = $urandom & 32'hffff_fffe;
    anpc_v = $urandom & 32'hffff_fffe;
    ivec_v = 8'($urandom);
    @(posedge CLK);
    SR_IN <= sr_v;
    SP_IN <= sp_v;
    VBR_IN <= vbr_v;
    BR_TARGET <= brt_v;
    AERR_NEXT_PC <= anpc_v;
    IRQ_VEC <= ivec_v;
  endtask

  task automatic dec(input logic [15:0] op, input logic [31:0] pc);
    @(posedge CLK);
    DEC_VALID <= 1'b1;
    DEC_OPCODE <= op;
    DEC_PC <= pc;
    DEC_NEXT_PC <= pc + 32'h2;
  endtask

  task automatic settle;
    int n;
    @(posedge CLK);
    DEC_VALID <= 1'b0;
    n = 0;
    while ((exp_q.size() != 0 || EXC_BUSY !== 1'b0) && n < 200)
    begin
      @(posedge CLK);
      n++;
    end
    if (n == 200)
      fails++;
    IRQ_REQ <= 1'b0;
    repeat (2) @(posedge CLK);
  endtask

  // address error pending from the second decode when irq is 0, interrupt raised with it when irq is 1; taken at third
  task automatic blocked(input logic [15:0] op1, input logic [15:0] op2, input bit irq);
    setup(2'h0, 2'h0);
    exp_seq(sp_v, irq ? pc_v + 32'h4 : anpc_v, irq ? ivec_v : VEC_AERR_DEF, !irq);
    dec(op1, pc_v);
    AERR_REQ <= !irq;
    dec(op2, pc_v + 32'h2);
    IRQ_REQ <= irq;
    AERR_REQ <= 1'b0;
    dec(16'h0000, pc_v + 32'h4);
    settle;
  endtask

  ////////////////////////////////////////
  initial
  begin
    logic [15:0] op;
    void'($urandom(85363));
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (4)
    begin
      setup(2'h0, 2'h0);
      op = {GRP_TRAP, 4'h0, 8'($urandom)};
      exp_seq(sp_v, pc_v + 32'h2, op[7:0], 1'b0);
      dec(op, pc_v);
      settle;
    end
    for (int i = 0; i < 10; i++)
    begin
      setup(2'h0, 2'h0);
      exp_seq(sp_v, brt_v, VEC_SLOT_DEF, 1'b0);
      dec({4'(1 + i % 6), 12'h0}, pc_v);
      dec((i < 9) ? {4'(1 + i), 12'h0} : 16'hc000, pc_v + 32'h2);
      settle;
    end
    setup(2'h0, 2'h0);
    exp_seq(sp_v, pc_v + 32'h2, VEC_GEN_DEF, 1'b0);
    dec(16'hb000, pc_v);
    dec(16'ha900, pc_v + 32'h2);
    settle;
    for (int i = 0; i < 6; i++)
      blocked({4'(1 + i), 12'h0}, 16'h0000, 1'b1);
    for (int i = 0; i < 8; i++)
      blocked({GRP_XFER, 4'(i), 8'h0}, 16'h0000, 1'b1);
    for (int i = 0; i < 8; i++)
      blocked({4'(1 + i % 6), 12'h0}, {GRP_XFER, 4'(i), 8'h0}, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      setup(2'(2 - 2 * j), 2'(j));
      exp_seq(sp_v, pc_v + 32'h2, 8'h20, 1'b0);
      dec({GRP_TRAP, 4'h0, 8'h20}, pc_v);
      settle;
    end
    complete_run;
  end

  initial
  begin
    repeat (20000) @(posedge CLK);
    fails++;
    complete_run;
  end
endmodule
